//--- eeprom_flash_write_control.sv
// Purpose: Special register front end for data EEPROM and flash writes.
// Assumes: One core clock; resetn covers all resets, powerOnReset marks POR.
// Notes:   Flash array lies outside; this block drives its strobes.
`timescale 1ns/10ps
`default_nettype none

module eeprom_flash_write_control #(
    parameter int unsigned PhaseCycles = nvm_pkg::PHASE_CYCLES,
    parameter int unsigned Depth = 256
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic powerOnReset,
    input wire logic externalResetPin,
    input wire logic watchdogTimerReset,
    input wire logic [11:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic cpuStall,
    output logic [21:0] nvmAddr,
    output logic [7:0] nvmData,
    output logic nvmSpaceFlash,
    output logic nvmSpaceConfig,
    output logic nvmEraseStrobe,
    output logic nvmProgStrobe
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0] eepromByte_r;
    logic [7:0] eepromLocation_r;
    logic [7:0] tableLatch_r;
    logic [21:0] tablePointer_r;
    logic memorySpaceSelect_r;
    logic configSpaceSelect_r;
    logic rowErase_r;
    logic writeErrorFlag_r;
    logic writeEnableBit_r;
    logic writeGo_r;
    logic readGo_r;
    logic [4:0] intEnableTwo_r;
    logic [4:0] intFlagsTwo_r;
    logic [4:0] intPriorityTwo_r;
    logic [7:0] intControl_r;
    logic [7:0] opAddr_r;
    logic [7:0] opData_r;
    logic opIsEeprom_r;
    logic [7:0] eepromArray [Depth];
    nvm_pkg::unlock_t unlock_r;
    nvm_pkg::op_state_t state_r;
    logic phaseDone;
    logic eepromTarget;
    logic startWrite;
    logic startRead;
    logic phaseStart;
    logic finishWrite;
    logic [7:0] readValue;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction
    function automatic logic wrHit(input logic [11:0] off);
        wrHit = sfrWrite && hit(sfrAddr, off);
    endfunction
    // ****************************************
    // Start and finish decode
    // ****************************************
    assign eepromTarget = !memorySpaceSelect_r && !configSpaceSelect_r;
    // Go is refused unless enabled and freshly unlocked
    assign startWrite = wrHit(nvm_pkg::OFF_NVM_CONTROL) && sfrWdata[nvm_pkg::CTRL_WRITE_GO]
        && writeEnableBit_r && (unlock_r == nvm_pkg::UNLOCK_ARMED)
        && (state_r == nvm_pkg::OP_IDLE);
    assign startRead = wrHit(nvm_pkg::OFF_NVM_CONTROL) && sfrWdata[nvm_pkg::CTRL_READ_GO]
        && (state_r == nvm_pkg::OP_IDLE) && !readGo_r;
    assign phaseStart = startWrite
        || (state_r == nvm_pkg::OP_ERASE && phaseDone && opIsEeprom_r);
    assign finishWrite = phaseDone
        && (state_r == nvm_pkg::OP_PROGRAM || !opIsEeprom_r);
    nvm_phase_timer #(
        .Cycles(PhaseCycles)
    ) phaseTimer (
        .clock(clock),
        .resetn(resetn),
        .start(phaseStart),
        .done(phaseDone)
    );

    // ****************************************
    // Unlock sequence tracker
    // ****************************************
    // Any other register write in between breaks the sequence
    always_ff @(posedge clock) begin
        if (!resetn) begin
            unlock_r <= nvm_pkg::UNLOCK_IDLE;
        end else if (sfrWrite) begin
            if (hit(sfrAddr, nvm_pkg::OFF_NVM_UNLOCK)
                && sfrWdata == nvm_pkg::UNLOCK_KEY_FIRST) begin
                unlock_r <= nvm_pkg::UNLOCK_HALF;
            end else if (hit(sfrAddr, nvm_pkg::OFF_NVM_UNLOCK)
                && sfrWdata == nvm_pkg::UNLOCK_KEY_SECOND
                && unlock_r == nvm_pkg::UNLOCK_HALF) begin
                unlock_r <= nvm_pkg::UNLOCK_ARMED;
            end else begin
                unlock_r <= nvm_pkg::UNLOCK_IDLE;
            end
        end
    end

    // ****************************************
    // Write sequencer
    // ****************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= nvm_pkg::OP_IDLE;
            opAddr_r <= 8'h00;
            opData_r <= 8'h00;
            opIsEeprom_r <= 1'b0;
        end else begin
            unique case (state_r)
                nvm_pkg::OP_IDLE: begin
                    if (startWrite) begin
                        opAddr_r <= eepromLocation_r;
                        opData_r <= eepromByte_r;
                        opIsEeprom_r <= eepromTarget;
                        if (eepromTarget || rowErase_r) begin
                            state_r <= nvm_pkg::OP_ERASE;
                        end else begin
                            state_r <= nvm_pkg::OP_PROGRAM;
                        end
                    end
                end
                nvm_pkg::OP_ERASE: begin
                    if (phaseDone) begin
                        state_r <= opIsEeprom_r ? nvm_pkg::OP_PROGRAM : nvm_pkg::OP_IDLE;
                    end
                end
                nvm_pkg::OP_PROGRAM: begin
                    if (phaseDone) begin
                        state_r <= nvm_pkg::OP_IDLE;
                    end
                end
                default: begin
                    state_r <= nvm_pkg::OP_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Data EEPROM array
    // ****************************************
    // Nonvolatile contents: no reset on purpose
    always_ff @(posedge clock) begin
        if (startWrite && eepromTarget) begin
            eepromArray[eepromLocation_r] <= nvm_pkg::ERASED_BYTE;
        end else if (finishWrite && opIsEeprom_r) begin
            eepromArray[opAddr_r] <= opData_r;
        end
    end

    // ****************************************
    // Byte and location registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            eepromByte_r <= nvm_pkg::BYTE_RESET;
            eepromLocation_r <= nvm_pkg::BYTE_RESET;
        end else begin
            if (readGo_r && eepromTarget) begin
                eepromByte_r <= eepromArray[eepromLocation_r];
            end else if (wrHit(nvm_pkg::OFF_EEPROM_BYTE)) begin
                eepromByte_r <= sfrWdata;
            end
            if (wrHit(nvm_pkg::OFF_EEPROM_LOCATION)) begin
                eepromLocation_r <= sfrWdata;
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Space and erase bits are frozen while a write runs
    always_ff @(posedge clock) begin
        if (!resetn) begin
            if (powerOnReset) begin
                memorySpaceSelect_r <= 1'b0;
                configSpaceSelect_r <= 1'b0;
            end
            rowErase_r <= 1'b0;
            writeEnableBit_r <= 1'b0;
            writeGo_r <= 1'b0;
            readGo_r <= 1'b0;
        end else begin
            readGo_r <= startRead;
            if (finishWrite) begin
                writeGo_r <= 1'b0;
                if (!opIsEeprom_r && state_r == nvm_pkg::OP_ERASE) begin
                    rowErase_r <= 1'b0;
                end
            end else if (startWrite) begin
                writeGo_r <= 1'b1;
            end
            if (wrHit(nvm_pkg::OFF_NVM_CONTROL)) begin
                writeEnableBit_r <= sfrWdata[nvm_pkg::CTRL_WRITE_ENABLE];
                if (state_r == nvm_pkg::OP_IDLE) begin
                    memorySpaceSelect_r <= sfrWdata[nvm_pkg::CTRL_SPACE_FLASH];
                    configSpaceSelect_r <= sfrWdata[nvm_pkg::CTRL_SPACE_CONFIG];
                    rowErase_r <= sfrWdata[nvm_pkg::CTRL_ROW_ERASE];
                end
            end
        end
    end
    // Error flag survives warm resets so software can check it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            if (powerOnReset) begin
                writeErrorFlag_r <= 1'b0;
            end else if (state_r != nvm_pkg::OP_IDLE
                && (externalResetPin || watchdogTimerReset)) begin
                writeErrorFlag_r <= 1'b1;
            end
        end else if (wrHit(nvm_pkg::OFF_NVM_CONTROL)) begin
            writeErrorFlag_r <= sfrWdata[nvm_pkg::CTRL_WRITE_ERROR];
        end
    end

    // ****************************************
    // Interrupt-related registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            intEnableTwo_r <= nvm_pkg::INT_ENABLE_TWO_RESET;
            intFlagsTwo_r <= nvm_pkg::INT_FLAGS_TWO_RESET;
            intPriorityTwo_r <= nvm_pkg::INT_PRIORITY_TWO_RESET;
            intControl_r <= 8'h00;
        end else begin
            if (wrHit(nvm_pkg::OFF_INT_ENABLE_TWO)) begin
                intEnableTwo_r <= sfrWdata[4:0];
            end
            if (wrHit(nvm_pkg::OFF_INT_PRIORITY_TWO)) begin
                intPriorityTwo_r <= sfrWdata[4:0];
            end
            if (wrHit(nvm_pkg::OFF_INTERRUPT_CONTROL)) begin
                intControl_r <= sfrWdata;
            end
            if (wrHit(nvm_pkg::OFF_INT_FLAGS_TWO)) begin
                intFlagsTwo_r <= sfrWdata[4:0];
            end
            // Completion beats a same-cycle software clear
            if (finishWrite) begin
                intFlagsTwo_r[nvm_pkg::FLAGS_WRITE_DONE] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Table pointer and latch
    // ****************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tablePointer_r <= nvm_pkg::TABLE_PTR_RESET;
            tableLatch_r <= nvm_pkg::BYTE_RESET;
        end else begin
            if (wrHit(nvm_pkg::OFF_TABLE_PTR_LOW)) begin
                tablePointer_r[7:0] <= sfrWdata;
            end
            if (wrHit(nvm_pkg::OFF_TABLE_PTR_HIGH)) begin
                tablePointer_r[15:8] <= sfrWdata;
            end
            if (wrHit(nvm_pkg::OFF_TABLE_PTR_UPPER)) begin
                tablePointer_r[21:16] <= sfrWdata[5:0];
            end
            if (wrHit(nvm_pkg::OFF_TABLE_LATCH)) begin
                tableLatch_r <= sfrWdata;
            end
        end
    end

    // ****************************************
    // Flash side outputs
    // ****************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            nvmAddr <= 22'h000000;
            nvmData <= 8'h00;
            nvmSpaceFlash <= 1'b0;
            nvmSpaceConfig <= 1'b0;
            nvmEraseStrobe <= 1'b0;
            nvmProgStrobe <= 1'b0;
            cpuStall <= 1'b0;
        end else begin
            nvmEraseStrobe <= startWrite && !eepromTarget && rowErase_r;
            nvmProgStrobe <= startWrite && !eepromTarget && !rowErase_r;
            if (startWrite && !eepromTarget) begin
                nvmAddr <= tablePointer_r;
                nvmData <= tableLatch_r;
                nvmSpaceFlash <= memorySpaceSelect_r;
                nvmSpaceConfig <= configSpaceSelect_r;
            end
            // Core halts for the whole flash operation
            cpuStall <= (startWrite && !eepromTarget)
                || (state_r != nvm_pkg::OP_IDLE && !opIsEeprom_r && !finishWrite);
        end
    end

    // ****************************************
    // Read-back
    // ****************************************
    always_comb begin
        readValue = nvm_pkg::READ_ZERO;
        unique case (sfrAddr)
            nvm_pkg::OFF_INT_ENABLE_TWO: readValue = {3'h0, intEnableTwo_r};
            nvm_pkg::OFF_INT_FLAGS_TWO: readValue = {3'h0, intFlagsTwo_r};
            nvm_pkg::OFF_INT_PRIORITY_TWO: readValue = {3'h0, intPriorityTwo_r};
            nvm_pkg::OFF_EEPROM_BYTE: readValue = eepromByte_r;
            nvm_pkg::OFF_EEPROM_LOCATION: readValue = eepromLocation_r;
            nvm_pkg::OFF_NVM_CONTROL: readValue = {memorySpaceSelect_r, configSpaceSelect_r,
                1'b0, rowErase_r, writeErrorFlag_r, writeEnableBit_r, writeGo_r, readGo_r};
            nvm_pkg::OFF_NVM_UNLOCK: readValue = nvm_pkg::READ_ZERO;
            nvm_pkg::OFF_INTERRUPT_CONTROL: readValue = intControl_r;
            nvm_pkg::OFF_TABLE_LATCH: readValue = tableLatch_r;
            nvm_pkg::OFF_TABLE_PTR_LOW: readValue = tablePointer_r[7:0];
            nvm_pkg::OFF_TABLE_PTR_HIGH: readValue = tablePointer_r[15:8];
            nvm_pkg::OFF_TABLE_PTR_UPPER: readValue = {2'h0, tablePointer_r[21:16]};
            default: readValue = nvm_pkg::READ_ZERO;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sfrRdata <= 8'h00;
        end else begin
            sfrRdata <= readValue;
        end
    end

endmodule
`default_nettype wire

//--- eeprom_flash_write_control_chk.sv
// Purpose: Port-level checks for the nonvolatile write control block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Stall bound derives from the phase count parameter.
`timescale 1ns/10ps
`default_nettype none

module eeprom_flash_write_control_chk #(
    parameter int unsigned PhaseCycles = 50
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [11:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic cpuStall,
    input wire logic nvmSpaceFlash,
    input wire logic nvmSpaceConfig,
    input wire logic nvmEraseStrobe,
    input wire logic nvmProgStrobe
);
    // ********
    // Unlock and stall tracking
    // ********
    localparam int StallMax = 2 * (PhaseCycles + 1) + 4;
    logic [1:0] keys_r;
    logic [2:0] sinceGo_r;
    int stallCnt_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            keys_r <= 2'h0;
        end else if (sfrWrite) begin
            if (sfrAddr == 12'hfa7 && sfrWdata == 8'h55) begin
                keys_r <= 2'h1;
            end else if (keys_r == 2'h1 && sfrAddr == 12'hfa7 && sfrWdata == 8'haa) begin
                keys_r <= 2'h2;
            end else begin
                keys_r <= 2'h0;
            end
        end
    end

    // Only a go write that follows both keys may start the array
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sinceGo_r <= 3'h7;
        end else if (sfrWrite && sfrAddr == 12'hfa6 && sfrWdata[1] && keys_r == 2'h2) begin
            sinceGo_r <= 3'h0;
        end else if (sinceGo_r != 3'h7) begin
            sinceGo_r <= sinceGo_r + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !cpuStall) begin
            stallCnt_r <= 0;
        end else begin
            stallCnt_r <= stallCnt_r + 1;
        end
    end

    a_unlock_reads_zero: assert property (@(posedge clock) disable iff (!resetn)
        (sfrAddr == 12'hfa7) |=> (sfrRdata == 8'h00)) else $error("unlock register read nonzero");
    a_upper_ptr_bits: assert property (@(posedge clock) disable iff (!resetn)
        (sfrAddr == 12'hff8) |=> (sfrRdata[7:6] == 2'h0)) else $error("pointer upper bits set");
    a_flag_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
        (sfrAddr == 12'hfa1) |=> (sfrRdata[7:5] == 3'h0)) else $error("flag reserved bits set");
    a_prog_strobe_pulse: assert property (@(posedge clock) disable iff (!resetn)
        nvmProgStrobe |=> !nvmProgStrobe) else $error("program strobe too long");
    a_erase_strobe_pulse: assert property (@(posedge clock) disable iff (!resetn)
        nvmEraseStrobe |=> !nvmEraseStrobe) else $error("erase strobe too long");
    a_go_needs_unlock: assert property (@(posedge clock) disable iff (!resetn)
        (nvmProgStrobe || nvmEraseStrobe) |-> (sinceGo_r <= 3'h2)) else $error("unlocked start");
    a_strobe_space_set: assert property (@(posedge clock) disable iff (!resetn)
        (nvmProgStrobe || nvmEraseStrobe) |-> (nvmSpaceFlash || nvmSpaceConfig))
        else $error("array strobe without flash space");
    a_stall_follows_go: assert property (@(posedge clock) disable iff (!resetn)
        nvmProgStrobe |=> cpuStall [*2]) else $error("no stall after program start");
    a_stall_bounded: assert property (@(posedge clock) disable iff (!resetn)
        stallCnt_r <= StallMax) else $error("stall longer than timed phases");
    a_reset_clears_out: assert property (@(posedge clock) disable iff (!resetn)
        $rose(resetn) |-> (sfrRdata == 8'h00 && !cpuStall)) else $error("outputs set after reset");
endmodule

bind eeprom_flash_write_control eeprom_flash_write_control_chk #(.PhaseCycles(PhaseCycles)) i_chk (
    .clock(clock), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .cpuStall(cpuStall),
    .nvmSpaceFlash(nvmSpaceFlash), .nvmSpaceConfig(nvmSpaceConfig),
    .nvmEraseStrobe(nvmEraseStrobe), .nvmProgStrobe(nvmProgStrobe)
);
`default_nettype wire

//--- nvm_phase_timer.sv
// Purpose: Self-timed phase counter for erase and program phases.
// Assumes: Start is a one-cycle pulse while the timer is idle.
// Notes:   Done is a one-cycle pulse; reset abandons a running phase.
`timescale 1ns/10ps
`default_nettype none

module nvm_phase_timer #(
    parameter int unsigned Cycles = nvm_pkg::PHASE_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    output logic done
);

    logic [15:0] count_r;
    logic running_r;

    // ****************************************
    // Countdown
    // ****************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            count_r <= 16'h0000;
            running_r <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_r <= 16'(Cycles - 1);
                running_r <= 1'b1;
            end else if (running_r) begin
                if (count_r == 16'h0000) begin
                    running_r <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_r <= count_r - 16'h0001;
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- nvm_pkg.sv
// Purpose: Shared constants for the nonvolatile write control block.
// Assumes: 12-bit special function register addresses, byte-wide data.
// Notes:   Constants below set the behaviour the block keeps.

package nvm_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] OFF_INT_ENABLE_TWO = 12'hfa0;
    localparam logic [11:0] OFF_INT_FLAGS_TWO = 12'hfa1;
    localparam logic [11:0] OFF_INT_PRIORITY_TWO = 12'hfa2;
    localparam logic [11:0] OFF_EEPROM_BYTE = 12'hfa8;
    localparam logic [11:0] OFF_EEPROM_LOCATION = 12'hfa9;
    localparam logic [11:0] OFF_NVM_CONTROL = 12'hfa6;
    localparam logic [11:0] OFF_NVM_UNLOCK = 12'hfa7;
    localparam logic [11:0] OFF_INTERRUPT_CONTROL = 12'hff2;
    localparam logic [11:0] OFF_TABLE_LATCH = 12'hff5;
    localparam logic [11:0] OFF_TABLE_PTR_LOW = 12'hff6;
    localparam logic [11:0] OFF_TABLE_PTR_HIGH = 12'hff7;
    localparam logic [11:0] OFF_TABLE_PTR_UPPER = 12'hff8;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTRL_SPACE_FLASH = 7;
    localparam int CTRL_SPACE_CONFIG = 6;
    localparam int CTRL_ROW_ERASE = 4;
    localparam int CTRL_WRITE_ERROR = 3;
    localparam int CTRL_WRITE_ENABLE = 2;
    localparam int CTRL_WRITE_GO = 1;
    localparam int CTRL_READ_GO = 0;
    localparam int FLAGS_WRITE_DONE = 4;

    // ****************************************
    // Reset values and unlock keys
    // ****************************************
    localparam logic [4:0] INT_ENABLE_TWO_RESET = 5'h00;
    localparam logic [4:0] INT_FLAGS_TWO_RESET = 5'h00;
    localparam logic [4:0] INT_PRIORITY_TWO_RESET = 5'h1f;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [21:0] TABLE_PTR_RESET = 22'h000000;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int PHASE_TIME_NS = 2000;
    localparam int PHASE_CYCLES = (PHASE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_HALF, UNLOCK_ARMED} unlock_t;
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROGRAM} op_state_t;

endpackage

//--- tb.sv
// Purpose: Self-checking bench for the nonvolatile write control block.
// Assumes: Phase count cut to 4 cycles; array holds unknowns until written.
// Notes:   Register rows first, then byte writes, refusals, flash and resets.
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    typedef struct {logic [11:0] a; logic [7:0] wd; logic [7:0] ex; logic [7:0] rs;} row_t;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic powerOnReset = 1'b1;
    logic externalResetPin = 1'b0;
    logic watchdogTimerReset = 1'b0;
    logic [11:0] sfrAddr = 12'h000;
    logic sfrWrite = 1'b0;
    logic [7:0] sfrWdata = 8'h00;
    logic [7:0] sfrRdata, nvmData, v, capData;
    logic [21:0] nvmAddr, capAddr;
    logic cpuStall, nvmSpaceFlash, nvmSpaceConfig, nvmEraseStrobe, nvmProgStrobe, capFlash, capCfg;
    int compares = 0;
    int miscompares = 0;
    int progCnt = 0;
    int eraseCnt = 0;
    int pc0, ec0;
    logic [7:0] modes[3] = '{8'h84, 8'h94, 8'h44};
    row_t rows[11] = '{'{12'hfa0, 8'hff, 8'h1f, 8'h00}, '{12'hfa1, 8'h1f, 8'h1f, 8'h00},
        '{12'hfa2, 8'h00, 8'h00, 8'h1f}, '{12'hfa7, 8'h55, 8'h00, 8'h00},
        '{12'hfa8, 8'ha5, 8'ha5, 8'h00}, '{12'hfa9, 8'hff, 8'hff, 8'h00},
        '{12'hff5, 8'h5a, 8'h5a, 8'h00}, '{12'hff6, 8'hc3, 8'hc3, 8'h00},
        '{12'hff7, 8'h3c, 8'h3c, 8'h00}, '{12'hff8, 8'hff, 8'h3f, 8'h00},
        '{12'h3ff, 8'hff, 8'h00, 8'h00}};

    eeprom_flash_write_control #(.PhaseCycles(4), .Depth(256)) i_dut (
        .clock(clock), .resetn(resetn), .powerOnReset(powerOnReset),
        .externalResetPin(externalResetPin), .watchdogTimerReset(watchdogTimerReset),
        .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .cpuStall(cpuStall), .nvmAddr(nvmAddr), .nvmData(nvmData),
        .nvmSpaceFlash(nvmSpaceFlash), .nvmSpaceConfig(nvmSpaceConfig),
        .nvmEraseStrobe(nvmEraseStrobe), .nvmProgStrobe(nvmProgStrobe)
    );

    always #20 clock = ~clock;

    // Edge-sampled, so registered strobes are seen without a race
    always @(posedge clock) begin
        if ((nvmProgStrobe | nvmEraseStrobe) === 1'b1) begin
            capAddr = nvmAddr;
            capData = nvmData;
            capFlash = nvmSpaceFlash;
            capCfg = nvmSpaceConfig;
        end
        if (nvmProgStrobe === 1'b1) progCnt++;
        if (nvmEraseStrobe === 1'b1) eraseCnt++;
    end

    // ********
    // Stimulus tasks
    // ********
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        sfrWrite <= 1'b0;
        sfrAddr <= a;
        @(posedge clock);
        #1 v = sfrRdata;
    endtask

    task automatic go(input logic [7:0] c);
        wr(12'hfa6, c);
        wr(12'hfa7, 8'h55);
        wr(12'hfa7, 8'haa);
        wr(12'hfa6, c | 8'h02);
        rd(12'hfa6);
    endtask

    task automatic waitDone;
        for (int i = 0; i < 40; i++) begin
            rd(12'hfa6);
            if (v[1] === 1'b0) break;
        end
        `CHK(v[1], 1'b0)
    endtask

    task automatic hit(input logic p, input logic e, input logic w);
        @(posedge clock);
        sfrWrite <= 1'b0;
        resetn <= 1'b0;
        powerOnReset <= p;
        externalResetPin <= e;
        watchdogTimerReset <= w;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        powerOnReset <= 1'b0;
        externalResetPin <= 1'b0;
        watchdogTimerReset <= 1'b0;
    endtask

    task automatic conclude;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        conclude();
    end

    // ********
    // Tests
    // ********
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        powerOnReset <= 1'b0;
        rd(12'hfa6);
        `CHK(v[3:0], 4'h0)
        foreach (rows[i]) begin
            rd(rows[i].a);
            `CHK(v, rows[i].rs)
            wr(rows[i].a, rows[i].wd);
            rd(rows[i].a);
            `CHK(v, rows[i].ex)
        end
        wr(12'hfa1, 8'h00);
        foreach (modes[i]) begin
            wr(12'hfa9, 8'hff);
            wr(12'hfa8, modes[i]);
            go(8'h04);
            `CHK(v[1], 1'b1)
            wr(12'hfa6, 8'h04);
            rd(12'hfa1);
            `CHK(v[4], 1'b0)
            rd(12'hfa6);
            `CHK(v[1], 1'b1)
            waitDone();
            rd(12'hfa1);
            `CHK(v[4], 1'b1)
            wr(12'hfa1, 8'h00);
            wr(12'hfa8, 8'h00);
            wr(12'hfa6, 8'h01);
            rd(12'hfa6);
            `CHK(v[0], 1'b1)
            rd(12'hfa8);
            `CHK(v, modes[i])
        end
        rd(12'hfa1);
        `CHK(v[4], 1'b0)
        wr(12'hfa6, 8'h04);
        wr(12'hfa6, 8'h06);
        rd(12'hfa6);
        `CHK(v[1], 1'b0)
        go(8'h00);
        `CHK(v[1], 1'b0)
        wr(12'hfa6, 8'h04);
        wr(12'hfa7, 8'h55);
        wr(12'hfa9, 8'h00);
        wr(12'hfa7, 8'haa);
        wr(12'hfa6, 8'h06);
        rd(12'hfa6);
        `CHK(v[1], 1'b0)
        wr(12'hff8, 8'h2a);
        wr(12'hff7, 8'h12);
        wr(12'hff6, 8'h34);
        wr(12'hff5, 8'hc7);
        foreach (modes[i]) begin
            pc0 = progCnt;
            ec0 = eraseCnt;
            go(modes[i]);
            `CHK(cpuStall, 1'b1)
            waitDone();
            `CHK(cpuStall, 1'b0)
            `CHK(eraseCnt - ec0, int'(modes[i][4]))
            `CHK(progCnt - pc0, int'(!modes[i][4]))
            `CHK(capAddr, 22'h2a1234)
            `CHK(capData, 8'hc7)
            `CHK(capFlash, modes[i][7])
            `CHK(capCfg, modes[i][6])
            `CHK(v[4], 1'b0)
        end
        for (int s = 0; s < 2; s++) begin
            wr(12'hfa9, 8'h10);
            wr(12'hfa8, 8'h77);
            go(8'h04);
            hit(1'b0, s == 0, s == 1);
            rd(12'hfa6);
            `CHK(v[3], 1'b1)
            rd(12'hfa8);
            `CHK(v, 8'h00)
            rd(12'hfa9);
            `CHK(v, 8'h00)
            wr(12'hfa9, 8'h10);
            wr(12'hfa8, 8'h77);
            go(8'h04);
            waitDone();
            wr(12'hfa6, 8'h01);
            rd(12'hfa6);
            rd(12'hfa8);
            `CHK(v, 8'h77)
            hit(1'b1, 1'b0, 1'b0);
            rd(12'hfa6);
            `CHK(v[3:2], 2'h0)
        end
        hit(1'b0, 1'b1, 1'b0);
        rd(12'hfa6);
        `CHK(v[3], 1'b0)
        conclude();
    end
endmodule
`default_nettype wire
